// *** pkg/vcd_cfg.svh ***
/*
 * Offsets, field positions, reset values and fixed sizes of the virtual
 * CPU interface control and deactivate block.
 * Assumes byte addresses on a 13-bit register address and 32-bit data.
 */
`ifndef VCD_CFG_SVH
`define VCD_CFG_SVH

// ==========================================================================
// Register offsets
`define VCD_OFS_CONTROL       13'h0000
`define VCD_OFS_BINARY_POINT  13'h0008
`define VCD_OFS_DEACTIVATE    13'h1000

// ==========================================================================
// Control fields
`define VCD_CTL_SPLIT_MODE    9
`define VCD_CTL_COMMON_SPLIT  4
`define VCD_CTL_FAST_SELECT   3
`define VCD_CTL_LEGACY_ACK    2
`define VCD_CTL_GRP1_ENABLE   1
`define VCD_CTL_GRP0_ENABLE   0
`define VCD_CTL_WRITE_MASK    32'h0000_021f
`define VCD_CTL_RESET         10'h000
`define VCD_BP_RESET          3'h0

// ==========================================================================
// Identifier layout and special values
`define VCD_ID_W              25
`define VCD_PHYS_W            10
`define VCD_SWGEN_LIMIT       10'h010
`define VCD_SPECIAL_FIRST     10'h3fc
`define VCD_ID_NO_GROUP1      25'h00003fe
`define VCD_ID_SPURIOUS       25'h00003ff

// ==========================================================================
// List entry count and state codes
`define VCD_ENTRIES           4
`define VCD_IDX_W             2
`define VCD_ST_ACTIVE_BIT     1
`define VCD_ST_PENDING_MASK   2'h1

`endif

// *** pkg/vcd_pkg.sv ***
/*
 * Types shared by the control and deactivate block and its entry matcher.
 * Assumes vcd_cfg.svh is on the include path.
 */
`include "vcd_cfg.svh"

package vcd_pkg;

	// ======================================================================
	// Identifiers and list entries
	typedef logic [`VCD_ID_W-1:0]   vcd_id_t;
	typedef logic [`VCD_PHYS_W-1:0] vcd_phys_t;
	typedef logic [`VCD_IDX_W-1:0]  vcd_idx_t;
	typedef logic [1:0]             vcd_state_t;
	typedef vcd_id_t   [`VCD_ENTRIES-1:0] vcd_id_arr_t;
	typedef vcd_state_t [`VCD_ENTRIES-1:0] vcd_state_arr_t;
	typedef vcd_phys_t [`VCD_ENTRIES-1:0] vcd_phys_arr_t;

	// Comparison key: reserved bits dropped, source field kept for software-made ones
	function automatic logic [12:0] vcd_id_key(input vcd_id_t id);
		logic [12:0] key;
		key = id[12:0];
		if (id[9:0] >= `VCD_SWGEN_LIMIT)
		begin
			key[12:10] = 3'h0;
		end
		return key;
	endfunction : vcd_id_key

endpackage : vcd_pkg

// *** sim/tb.sv ***
/*
 * Self-checking bench of the control and deactivate block.
 * Assumes registered answers and a deactivate outcome two edges after the write.
 */
`timescale 1ns/1ns
`include "vcd_cfg.svh"
`define CHK(g, e) check_val(32'(g), 32'(e))

module tb
	import vcd_pkg::*;
;
	logic clk_i, reset_n_i, reg_wr_i, reg_rd_i, hyp_wr, cw, pend0, pend1, tv, tg, ld, ldhw;
	logic [12:0] reg_addr_i;
	logic [31:0] reg_wdata_i, rdata, d;
	logic [2:0] hyp_d, hview, alias_bp;
	logic [7:0] m0, m1, mc, pc, dc, m;
	logic irq, fiq, drop, upd, miss, ph, mode;
	vcd_id_t tid, cid, ldid, ackid;
	vcd_idx_t ldix, uix;
	vcd_state_t lds, ust;
	vcd_phys_t pid, lph;
	vcd_id_arr_t eid;
	vcd_state_arr_t est;
	vcd_phys_arr_t eph;
	logic [`VCD_ENTRIES-1:0] ev, ehw;
	int n_fail = 0;
	int compares = 0;

	// ======================================================================
	// Clock, design and partner
	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	vcd_ctrl vcd_ctrl_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(rdata), .hyp_split_wr_i(hyp_wr), .hyp_split_data_i(hyp_d),
		.hyp_split_view_o(hview), .group_one_split_alias_i(alias_bp),
		.group_zero_preempt_mask_o(m0), .group_one_preempt_mask_o(m1),
		.group_zero_pending_i(pend0), .group_one_pending_i(pend1), .virtual_irq_o(irq),
		.virtual_fiq_o(fiq), .top_valid_i(tv), .top_group_i(tg), .top_id_i(tid),
		.ack_query_id_o(ackid), .completion_write_i(cw), .completion_id_i(cid),
		.priority_drop_o(drop), .entry_id_i(eid), .entry_state_i(est), .entry_valid_i(ev),
		.entry_hw_i(ehw), .entry_phys_id_i(eph), .entry_update_o(upd),
		.entry_update_index_o(uix), .entry_update_state_o(ust),
		.missing_completion_inc_o(miss), .phys_deactivate_o(ph),
		.phys_deactivate_id_o(pid), .split_completion_mode_o(mode));

	vcd_list_model vcd_list_model_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .load_i(ld),
		.load_idx_i(ldix), .load_id_i(ldid), .load_state_i(lds), .load_hw_i(ldhw),
		.entry_id_o(eid), .entry_state_o(est), .entry_valid_o(ev), .entry_hw_o(ehw),
		.entry_phys_id_o(eph), .upd_i(upd), .upd_idx_i(uix), .upd_state_i(ust),
		.miss_i(miss), .phys_i(ph), .phys_id_i(pid), .drop_i(drop), .miss_cnt_o(mc),
		.phys_cnt_o(pc), .drop_cnt_o(dc), .last_phys_o(lph));

	// ======================================================================
	// Shared tasks
	task check_val(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check_val

	// Automatic: the hang guard and the scenarios run it at the same time
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick

	// Write strobe held exactly one edge
	task wr(input logic [12:0] a, input logic [31:0] v);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		tick(1);
	endtask : wr

	task rd(input logic [12:0] a, output logic [31:0] v);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 v = rdata;
	endtask : rd

	task load(input vcd_idx_t i, input vcd_id_t id, input vcd_state_t s, input logic hw);
		@(posedge clk_i);
		ld <= 1'b1;
		ldix <= i;
		ldid <= id;
		lds <= s;
		ldhw <= hw;
		@(posedge clk_i);
		ld <= 1'b0;
	endtask : load

	// Deactivate write, then room for the two-edge answer
	task dir(input vcd_id_t id);
		wr(`VCD_OFS_DEACTIVATE, {7'h00, id});
		tick(3);
	endtask : dir

	task eoi(input vcd_id_t id);
		@(posedge clk_i);
		cw <= 1'b1;
		cid <= id;
		@(posedge clk_i);
		cw <= 1'b0;
		tick(3);
	endtask : eoi

	task end_test(input string s);
		$display("test %s done", s);
	endtask : end_test

	task report_and_stop;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	// Hang guard
	initial
	begin
		tick(20000);
		n_fail++;
		report_and_stop;
	end

	// ======================================================================
	// Scenarios; the guest only uses the memory-mapped view
	initial
	begin
		{reset_n_i, reg_wr_i, reg_rd_i, hyp_wr, cw, pend0, pend1, tv, tg, ld, ldhw} = '0;
		{reg_addr_i, reg_wdata_i, hyp_d, alias_bp, tid, cid, ldid, ldix, lds} = '0;
		tick(6);
		reset_n_i <= 1'b1;
		rd(`VCD_OFS_CONTROL, d); `CHK(d, 0);
		rd(`VCD_OFS_BINARY_POINT, d); `CHK(d, 0);
		`CHK(ackid, 25'h3ff);
		end_test("reset");
		// Reserved bits and unmapped places
		wr(`VCD_OFS_CONTROL, 32'hffff_ffff);
		wr(13'h0004, 32'hffff_ffff);
		rd(`VCD_OFS_CONTROL, d); `CHK(d, 32'h21f);
		wr(`VCD_OFS_BINARY_POINT, 32'hffff_fff5);
		rd(`VCD_OFS_BINARY_POINT, d); `CHK(d, 5);
		rd(`VCD_OFS_DEACTIVATE, d); `CHK(d, 0);
		rd(13'h0004, d); `CHK(d, 0);
		end_test("access");
		// Both views of the binary point
		@(posedge clk_i);
		hyp_wr <= 1'b1;
		hyp_d <= 3'h3;
		@(posedge clk_i);
		hyp_wr <= 1'b0;
		rd(`VCD_OFS_BINARY_POINT, d); `CHK(d, 3);
		wr(`VCD_OFS_BINARY_POINT, 32'h6);
		`CHK(hview, 3'h6);
		end_test("alias");
		// Every split point, common select set then clear
		alias_bp <= 3'h6;
		for (int b = 0; b < 8; b++)
		begin
			wr(`VCD_OFS_BINARY_POINT, 32'(b));
			tick(2);
			m = 8'hfe << b;
			`CHK(m0, m);
			`CHK(m1, m);
		end
		wr(`VCD_OFS_CONTROL, 32'h203);
		tick(2);
		`CHK(m1, 8'h80);
		end_test("split");
		// Presentation over enables, fast select and pending groups
		for (int i = 0; i < 32; i++)
		begin
			wr(`VCD_OFS_CONTROL, {28'h0, i[0], 1'b0, i[1], i[2]});
			pend0 <= i[3];
			pend1 <= i[4];
			tick(3);
			`CHK(irq, (i[4] & i[1]) | (i[3] & i[2] & !i[0]));
			`CHK(fiq, i[3] & i[2] & i[0]);
		end
		end_test("presentation");
		// Query answer; legacy bit set again here and cleared after
		tv <= 1'b1;
		tg <= 1'b1;
		tid <= 25'd42;
		wr(`VCD_OFS_CONTROL, 32'h0);
		tick(2);
		`CHK(ackid, 25'd1022);
		wr(`VCD_OFS_CONTROL, 32'h4);
		tick(2);
		`CHK(ackid, 25'd42);
		tg <= 1'b0;
		wr(`VCD_OFS_CONTROL, 32'h0);
		tick(2);
		`CHK(ackid, 25'd42);
		tv <= 1'b0;
		tick(3);
		`CHK(ackid, 25'h3ff);
		end_test("query");
		// Deactivation in both modes
		load(2'd0, 25'd40, 2'h2, 1'b1);
		load(2'd1, 25'd41, 2'h3, 1'b0);
		load(2'd2, 25'h803, 2'h2, 1'b1);
		load(2'd3, 25'd50, 2'h1, 1'b0);
		wr(`VCD_OFS_CONTROL, 32'h3);
		dir(25'd41);
		`CHK(est[1], 2'h3);
		eoi(25'd41);
		`CHK(est[1], 2'h1);
		`CHK(dc, 1);
		wr(`VCD_OFS_CONTROL, 32'h203);
		`CHK(mode, 1);
		eoi(25'd40);
		`CHK(dc, 2);
		`CHK(est[0], 2'h2);
		dir(25'd40);
		`CHK(est[0], 2'h0);
		`CHK(pc, 1);
		`CHK(lph, 10'd40 ^ 10'h200);
		dir(25'hc03);
		`CHK(mc, 1);
		`CHK(est[2], 2'h2);
		dir(25'h803);
		`CHK(est[2], 2'h0);
		`CHK(lph, 10'h003 ^ 10'h200);
		dir(25'h3fd);
		`CHK(mc, 1);
		`CHK(pc, 2);
		end_test("deactivate");
		report_and_stop;
	end
endmodule : tb

// *** sim/vcd_list_model.sv ***
/*
 * Model of the hypervisor list entries and the physical distributor.
 * Assumes the bench loads entries while no deactivation is in flight.
 */
`timescale 1ns/1ns
`include "vcd_cfg.svh"

module vcd_list_model
	import vcd_pkg::*;
(
	// Clock and reset
	input  wire logic      clk_i,
	input  wire logic      reset_n_i,
	// Entry loading by the bench
	input  wire logic      load_i,
	input  wire vcd_idx_t  load_idx_i,
	input  wire vcd_id_t   load_id_i,
	input  wire vcd_state_t load_state_i,
	input  wire logic      load_hw_i,
	// Entries seen by the block
	output vcd_id_arr_t    entry_id_o,
	output vcd_state_arr_t entry_state_o,
	output logic [`VCD_ENTRIES-1:0] entry_valid_o,
	output logic [`VCD_ENTRIES-1:0] entry_hw_o,
	output vcd_phys_arr_t  entry_phys_id_o,
	// Requests from the block
	input  wire logic      upd_i,
	input  wire vcd_idx_t  upd_idx_i,
	input  wire vcd_state_t upd_state_i,
	input  wire logic      miss_i,
	input  wire logic      phys_i,
	input  wire vcd_phys_t phys_id_i,
	input  wire logic      drop_i,
	// Tallies for the bench
	output logic [7:0]     miss_cnt_o,
	output logic [7:0]     phys_cnt_o,
	output logic [7:0]     drop_cnt_o,
	output vcd_phys_t      last_phys_o
);
	// ======================================================================
	// Entry table; the bench never aims at a pending-only entry
	// and keeps at most one active interrupt outside the table
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			entry_id_o      <= '0;
			entry_state_o   <= '0;
			entry_valid_o   <= '0;
			entry_hw_o      <= '0;
			entry_phys_id_o <= '0;
		end
		else if (load_i)
		begin
			entry_id_o[load_idx_i]      <= load_id_i;
			entry_state_o[load_idx_i]   <= load_state_i;
			entry_valid_o[load_idx_i]   <= 1'b1;
			entry_hw_o[load_idx_i]      <= load_hw_i;
			// Physical number differs from the virtual one on purpose
			entry_phys_id_o[load_idx_i] <= load_id_i[9:0] ^ 10'h200;
		end
		else if (upd_i)
		begin
			entry_state_o[upd_idx_i] <= upd_state_i;
		end
	end

	// Counter and distributor side only tally what arrives
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			miss_cnt_o  <= 8'h00;
			phys_cnt_o  <= 8'h00;
			drop_cnt_o  <= 8'h00;
			last_phys_o <= '0;
		end
		else
		begin
			miss_cnt_o <= miss_cnt_o + 8'(miss_i);
			phys_cnt_o <= phys_cnt_o + 8'(phys_i);
			drop_cnt_o <= drop_cnt_o + 8'(drop_i);
			if (phys_i)
			begin
				last_phys_o <= phys_id_i;
			end
		end
	end
endmodule : vcd_list_model

// *** verilog/vcd_ctrl.sv ***
/*
 * Control, binary point and deactivate registers of a virtual CPU interface.
 * Assumes a same-clock register port, list entries held by the hypervisor
 * side, and a distributor that takes one-cycle deactivate pulses.
 */
`timescale 1ns/1ns
`include "vcd_cfg.svh"

module vcd_ctrl
	import vcd_pkg::*;
(
	// Clock and reset
	input  wire logic           clk_i,
	input  wire logic           reset_n_i,
	// Guest register port
	input  wire logic           reg_wr_i,
	input  wire logic           reg_rd_i,
	input  wire logic [12:0]    reg_addr_i,
	input  wire logic [31:0]    reg_wdata_i,
	output logic      [31:0]    reg_rdata_o,
	// Hypervisor view of the binary point
	input  wire logic           hyp_split_wr_i,
	input  wire logic [2:0]     hyp_split_data_i,
	output logic      [2:0]     hyp_split_view_o,
	// Group one alias binary point, held elsewhere
	input  wire logic [2:0]     group_one_split_alias_i,
	// Preemption masks
	output logic      [7:0]     group_zero_preempt_mask_o,
	output logic      [7:0]     group_one_preempt_mask_o,
	// Pending groups and presentation
	input  wire logic           group_zero_pending_i,
	input  wire logic           group_one_pending_i,
	output logic                virtual_irq_o,
	output logic                virtual_fiq_o,
	// Highest pending entry and query answer
	input  wire logic           top_valid_i,
	input  wire logic           top_group_i,
	input  wire vcd_id_t        top_id_i,
	output vcd_id_t             ack_query_id_o,
	// Completion writes from the guest
	input  wire logic           completion_write_i,
	input  wire vcd_id_t        completion_id_i,
	output logic                priority_drop_o,
	// List entries
	input  wire vcd_id_arr_t    entry_id_i,
	input  wire vcd_state_arr_t entry_state_i,
	input  wire [`VCD_ENTRIES-1:0] entry_valid_i,
	input  wire [`VCD_ENTRIES-1:0] entry_hw_i,
	input  wire vcd_phys_arr_t  entry_phys_id_i,
	output logic                entry_update_o,
	output vcd_idx_t            entry_update_index_o,
	output vcd_state_t          entry_update_state_o,
	// Counter and distributor
	output logic                missing_completion_inc_o,
	output logic                phys_deactivate_o,
	output vcd_phys_t           phys_deactivate_id_o,
	// Split completion mode to the processing element
	output logic                split_completion_mode_o
);
	// ======================================================================
	// Register decode
	logic       ctl_wr;
	logic       bp_wr;
	logic       dir_wr;
	logic [9:0] control;
	logic [2:0] split_point;

	assign ctl_wr = reg_wr_i && (reg_addr_i == `VCD_OFS_CONTROL);
	assign bp_wr  = reg_wr_i && (reg_addr_i == `VCD_OFS_BINARY_POINT);
	assign dir_wr = reg_wr_i && (reg_addr_i == `VCD_OFS_DEACTIVATE);

	// Field taps
	logic split_mode;
	logic common_split;
	logic fast_select;
	logic legacy_ack;
	logic grp1_en;
	logic grp0_en;

	assign split_mode   = control[`VCD_CTL_SPLIT_MODE];
	assign common_split = control[`VCD_CTL_COMMON_SPLIT];
	assign fast_select  = control[`VCD_CTL_FAST_SELECT];
	assign legacy_ack   = control[`VCD_CTL_LEGACY_ACK];
	assign grp1_en      = control[`VCD_CTL_GRP1_ENABLE];
	assign grp0_en      = control[`VCD_CTL_GRP0_ENABLE];
	assign split_completion_mode_o = split_mode;

	// ======================================================================
	// Control register; reset to zero though software may not rely on it
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			control <= `VCD_CTL_RESET;
		end
		else if (ctl_wr)
		begin
			control <= reg_wdata_i[9:0] & 10'(`VCD_CTL_WRITE_MASK);
		end
	end

	// Binary point: one flop, two windows; hypervisor wins a collision
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			split_point <= `VCD_BP_RESET;
		end
		else if (hyp_split_wr_i)
		begin
			split_point <= hyp_split_data_i;
		end
		else if (bp_wr)
		begin
			split_point <= reg_wdata_i[2:0];
		end
	end

	assign hyp_split_view_o = split_point;

	// ======================================================================
	// Preemption masks: group priority is bits [7:n+1] for point n
	function automatic logic [7:0] vcd_preempt_mask(input logic [2:0] point);
		return 8'hfe << point;
	endfunction : vcd_preempt_mask

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			group_zero_preempt_mask_o <= 8'h00;
			group_one_preempt_mask_o  <= 8'h00;
		end
		else
		begin
			group_zero_preempt_mask_o <= vcd_preempt_mask(split_point);
			group_one_preempt_mask_o  <= common_split ? vcd_preempt_mask(split_point)
				: vcd_preempt_mask(group_one_split_alias_i);
		end
	end

	// ======================================================================
	// Presentation: registered so the lines never glitch
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			virtual_irq_o <= 1'b0;
			virtual_fiq_o <= 1'b0;
		end
		else
		begin
			virtual_irq_o <= (group_one_pending_i && grp1_en)
				|| (group_zero_pending_i && grp0_en && !fast_select);
			virtual_fiq_o <= group_zero_pending_i && grp0_en && fast_select;
		end
	end

	// ======================================================================
	// Query answer; group comes from the entry's own group field
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ack_query_id_o <= `VCD_ID_SPURIOUS;
		end
		else if (!top_valid_i)
		begin
			ack_query_id_o <= `VCD_ID_SPURIOUS;
		end
		else if (top_group_i && !legacy_ack)
		begin
			ack_query_id_o <= `VCD_ID_NO_GROUP1;
		end
		else
		begin
			ack_query_id_o <= top_id_i;
		end
	end

	// ======================================================================
	// Read data: deactivate is write-only and reads zero like holes
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			reg_rdata_o <= 32'h0000_0000;
		end
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				`VCD_OFS_CONTROL:      reg_rdata_o <= {22'h000000, control};
				`VCD_OFS_BINARY_POINT: reg_rdata_o <= {29'h00000000, split_point};
				default:               reg_rdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// ======================================================================
	// Deactivate request capture; mode selects the source
	logic    deact_req;
	vcd_id_t deact_id;
	logic    special_id;
	vcd_id_t req_id;
	logic    req_take;

	// Mode zero: completion deactivates, direct writes dropped as a safe
	// choice for the unpredictable case. Mode one: only direct writes.
	assign req_take = split_mode ? dir_wr : completion_write_i;
	assign req_id   = split_mode ? reg_wdata_i[`VCD_ID_W-1:0]
		: completion_id_i;
	assign special_id = (req_id[9:0] >= `VCD_SPECIAL_FIRST);

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			deact_req <= 1'b0;
			deact_id  <= '0;
		end
		else
		begin
			deact_req <= req_take && !special_id;
			deact_id  <= req_id;
		end
	end

	// Priority drop follows every completion write regardless of mode
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			priority_drop_o <= 1'b0;
		end
		else
		begin
			priority_drop_o <= completion_write_i;
		end
	end

	// ======================================================================
	// Entry search and outcome
	logic     hit;
	vcd_idx_t hit_index;

	vcd_entry_match u_match (
		.id_i          (deact_id),
		.entry_id_i    (entry_id_i),
		.entry_state_i (entry_state_i),
		.entry_valid_i (entry_valid_i),
		.hit_o         (hit),
		.index_o       (hit_index)
	);

	vcd_state_t hit_state;
	logic       hit_active;

	assign hit_state  = entry_state_i[hit_index];
	assign hit_active = hit_state[`VCD_ST_ACTIVE_BIT];

	// Non-active hit leaves everything alone: the guest broke the contract
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			entry_update_o           <= 1'b0;
			entry_update_index_o     <= '0;
			entry_update_state_o     <= 2'h0;
			missing_completion_inc_o <= 1'b0;
			phys_deactivate_o        <= 1'b0;
			phys_deactivate_id_o     <= '0;
		end
		else
		begin
			entry_update_o           <= deact_req && hit && hit_active;
			entry_update_index_o     <= hit_index;
			entry_update_state_o     <= hit_state & `VCD_ST_PENDING_MASK;
			missing_completion_inc_o <= deact_req && !hit;
			phys_deactivate_o        <= deact_req && hit && hit_active
				&& entry_hw_i[hit_index];
			phys_deactivate_id_o     <= entry_phys_id_i[hit_index];
		end
	end

	// ======================================================================
	// Checks
	sequence s_dir_taken;
		dir_wr && split_mode && (reg_wdata_i[9:0] < `VCD_SPECIAL_FIRST);
	endsequence

	property p_alias;
		@(posedge clk_i) disable iff (!reset_n_i)
		hyp_split_wr_i |=> (hyp_split_view_o == $past(hyp_split_data_i));
	endproperty
	a_alias: assert property (p_alias) else $error("split alias lost");

	property p_common;
		@(posedge clk_i) disable iff (!reset_n_i)
		$stable(control) && $stable(split_point) && common_split
		|=> group_one_preempt_mask_o == group_zero_preempt_mask_o;
	endproperty
	a_common: assert property (p_common) else $error("common split wrong");

	property p_fast;
		@(posedge clk_i) disable iff (!reset_n_i)
		virtual_fiq_o |-> $past(fast_select) && $past(grp0_en) && $past(group_zero_pending_i);
	endproperty
	a_fast: assert property (p_fast) else $error("fast line without select");

	property p_grp_gate;
		@(posedge clk_i) disable iff (!reset_n_i)
		!grp0_en && !grp1_en |=> !virtual_irq_o && !virtual_fiq_o;
	endproperty
	a_grp_gate: assert property (p_grp_gate) else $error("signal while off");

	property p_legacy;
		@(posedge clk_i) disable iff (!reset_n_i)
		top_valid_i && top_group_i && !legacy_ack |=> ack_query_id_o == `VCD_ID_NO_GROUP1;
	endproperty
	a_legacy: assert property (p_legacy) else $error("group one not hidden");

	property p_mode0_drop;
		@(posedge clk_i) disable iff (!reset_n_i)
		dir_wr && !split_mode && !completion_write_i |=> !deact_req;
	endproperty
	a_mode0_drop: assert property (p_mode0_drop) else $error("direct write in mode 0");

	property p_outcome;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_dir_taken |-> ##2 (entry_update_o || missing_completion_inc_o
			|| !$past(hit_active));
	endproperty
	a_outcome: assert property (p_outcome) else $error("deactivate lost");

	property p_hw;
		@(posedge clk_i) disable iff (!reset_n_i)
		phys_deactivate_o |-> entry_update_o && !missing_completion_inc_o;
	endproperty
	a_hw: assert property (p_hw) else $error("stray physical deactivate");

	property p_reserved;
		@(posedge clk_i) disable iff (!reset_n_i)
		reg_rd_i |=> reg_rdata_o[31:10] == 22'h000000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits set");

endmodule : vcd_ctrl

// *** verilog/vcd_entry_match.sv ***
/*
 * Searches the list entries for the identifier being deactivated.
 * Assumes entry contents are stable, same-clock inputs; purely combinational.
 */
`timescale 1ns/1ns
`include "vcd_cfg.svh"

module vcd_entry_match
	import vcd_pkg::*;
(
	// Identifier searched for
	input  wire vcd_id_t        id_i,
	// List entries
	input  wire vcd_id_arr_t    entry_id_i,
	input  wire vcd_state_arr_t entry_state_i,
	input  wire [`VCD_ENTRIES-1:0] entry_valid_i,
	// Result
	output logic                hit_o,
	output vcd_idx_t            index_o
);

	// ======================================================================
	// Per-entry compare
	logic [`VCD_ENTRIES-1:0] match;

	genvar g;
	generate
		for (g = 0; g < `VCD_ENTRIES; g++)
		begin : g_cmp
			// Entries in state inactive still count as present
			assign match[g] = entry_valid_i[g] &&
				(vcd_id_key(entry_id_i[g]) == vcd_id_key(id_i));
		end
	endgenerate

	// ======================================================================
	// Lowest matching entry wins; duplicates are a hypervisor error
	always_comb
	begin
		hit_o   = 1'b0;
		index_o = '0;
		for (int i = `VCD_ENTRIES - 1; i >= 0; i--)
		begin
			if (match[i])
			begin
				hit_o   = 1'b1;
				index_o = vcd_idx_t'(i);
			end
		end
	end

endmodule : vcd_entry_match
